// *** asc_ctrl.sv ***
// host controller driving the 16k x 1 static memory pins
// Summary of operation
// - select high idles; strobe picks read/write
// - read cycle at least grade cycle time
// - write strobe held high during reads
// - address and select change on the same edge
// - write cycle at least grade cycle time
// - select low long enough before write end
// - address stable long enough before write end
// - data stable long enough before write end
// - deselect for retention; wait after restore
`default_nettype none
module asc_ctrl #(
  parameter logic [1:0] GRADE = asc_pkg::GRADE_DEFAULT
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic [asc_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input wire logic REQ_DATA_I,
  input wire logic RETAIN_REQ_I,
  input wire logic SUPPLY_OK_I,
  input wire logic MEM_DOUT_I,
  output logic REQ_READY_O,
  output logic RD_VALID_O,
  output logic RD_DATA_O,
  output logic RETAINING_O,
  output logic [asc_pkg::ADDR_W-1:0] MEM_ADDR_O,
  output logic MEM_CS_N_O,
  output logic MEM_WE_N_O,
  output logic MEM_DIN_O
);
  localparam int CYC_NS = (GRADE == 2'h2) ? asc_pkg::T_CYCLE_NS_G2 :
    (GRADE == 2'h1) ? asc_pkg::T_CYCLE_NS_G1 : asc_pkg::T_CYCLE_NS_G0;
  localparam int CSW_NS = (GRADE == 2'h2) ? asc_pkg::T_CS_WR_NS_G2 :
    (GRADE == 2'h1) ? asc_pkg::T_CS_WR_NS_G1 : asc_pkg::T_CS_WR_NS_G0;
  localparam int DW_NS = (GRADE == 2'h2) ? asc_pkg::T_DATA_WR_NS_G2 :
    (GRADE == 2'h1) ? asc_pkg::T_DATA_WR_NS_G1 : asc_pkg::T_DATA_WR_NS_G0;
  localparam logic [asc_pkg::CYC_W-1:0] RD_CYC =
    asc_pkg::CYC_W'(asc_pkg::ns_to_cyc(CYC_NS));
  // the pulse must cover select and data hold-before-end
  localparam int PULSE_NS = (CSW_NS > DW_NS) ? CSW_NS : DW_NS;
  localparam logic [asc_pkg::CYC_W-1:0] WR_CYC =
    asc_pkg::CYC_W'(asc_pkg::ns_to_cyc(PULSE_NS));
  localparam logic [asc_pkg::CYC_W-1:0] WC_CYC =
    asc_pkg::CYC_W'(asc_pkg::ns_to_cyc(CYC_NS));
  // bus release after deselect before a new select may follow
  localparam logic [asc_pkg::CYC_W-1:0] OFF_CYC =
    asc_pkg::CYC_W'(asc_pkg::ns_to_cyc(asc_pkg::TURN_OFF_DELAY_NS));
  // last-count value sized to the counter, so its width may change
  localparam logic [asc_pkg::CYC_W-1:0] CNT_ONE =
    {{(asc_pkg::CYC_W-1){1'h0}}, 1'h1};

  asc_pkg::asc_state_e state_r, state_nxt;
  logic [asc_pkg::CYC_W-1:0] cnt_r, cnt_nxt;
  logic [asc_pkg::CYC_W-1:0] wc_r;
  logic take_req;
  logic take_wr;
  logic rd_last;
  logic sel_nxt;
  logic strobe_nxt;

  assign REQ_READY_O = (state_r == asc_pkg::ST_IDLE) && !RETAIN_REQ_I;
  // one accept term feeds counter, address and data latches alike
  assign take_req = REQ_READY_O && REQ_VALID_I;
  assign take_wr = take_req && REQ_WRITE_I;
  // last select cycle of a read; access time has elapsed by now
  assign rd_last = (state_r == asc_pkg::ST_RD) && (cnt_r == CNT_ONE);
  // pins follow the next state so they leave their flops in step
  assign sel_nxt = (state_nxt == asc_pkg::ST_RD) ||
    (state_nxt == asc_pkg::ST_WR_SETUP) ||
    (state_nxt == asc_pkg::ST_WR_PULSE);
  assign strobe_nxt = (state_nxt == asc_pkg::ST_WR_PULSE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    case (state_r)
      asc_pkg::ST_IDLE: begin
        if (RETAIN_REQ_I) begin
          state_nxt = asc_pkg::ST_RETAIN;
        end else if (REQ_VALID_I && REQ_WRITE_I) begin
          state_nxt = asc_pkg::ST_WR_SETUP;
        end else if (REQ_VALID_I) begin
          state_nxt = asc_pkg::ST_RD;
          cnt_nxt = RD_CYC;
        end
      end
      asc_pkg::ST_RD: begin
        // sample on the last cycle, access time has elapsed
        if (rd_last) begin
          state_nxt = asc_pkg::ST_RECOVER;
          cnt_nxt = OFF_CYC;
        end
      end
      asc_pkg::ST_WR_SETUP: begin
        // select and address go out one cycle before the strobe
        state_nxt = asc_pkg::ST_WR_PULSE;
        cnt_nxt = WR_CYC;
      end
      asc_pkg::ST_WR_PULSE: begin
        if (cnt_r == CNT_ONE) begin
          state_nxt = asc_pkg::ST_RECOVER;
          cnt_nxt = OFF_CYC;
        end
      end
      asc_pkg::ST_RECOVER: begin
        if (cnt_r == CNT_ONE && wc_r == '0) begin
          state_nxt = asc_pkg::ST_IDLE;
        end else if (cnt_r == '0 && wc_r == '0) begin
          state_nxt = asc_pkg::ST_IDLE;
        end
      end
      asc_pkg::ST_RETAIN: begin
        // one read cycle after supply returns before accesses resume
        if (!SUPPLY_OK_I || RETAIN_REQ_I) begin
          cnt_nxt = RD_CYC;
        end else if (cnt_r == '0) begin
          state_nxt = asc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = asc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_r <= asc_pkg::ST_IDLE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // whole write cycle length counted from address valid
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wc_r <= '0;
    end else if (take_wr) begin
      wc_r <= WC_CYC;
    end else if (wc_r != '0) begin
      wc_r <= wc_r - 1'b1;
    end
  end

  // address latched at acceptance, stable past the strobe rise
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      MEM_ADDR_O <= '0;
    end else if (take_req) begin
      MEM_ADDR_O <= REQ_ADDR_I;
    end
  end

  // data moves only on acceptance, so it outlasts the write end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      MEM_DIN_O <= 1'h0;
    end else if (take_req) begin
      MEM_DIN_O <= REQ_DATA_I;
    end
  end

  // select asserted on the same edge the address is latched, so neither leads
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      MEM_CS_N_O <= 1'b1;
    end else begin
      MEM_CS_N_O <= !sel_nxt;
    end
  end

  // strobe rises together with select; device stays floating then
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      MEM_WE_N_O <= 1'b1;
    end else begin
      MEM_WE_N_O <= !strobe_nxt;
    end
  end

  // one-cycle pulse; the host must take the bit while it stands
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      RD_VALID_O <= 1'h0;
    end else begin
      RD_VALID_O <= rd_last;
    end
  end

  // bit kept until the next read, sampled before select rises
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      RD_DATA_O <= 1'h0;
    end else if (rd_last) begin
      RD_DATA_O <= MEM_DOUT_I;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      RETAINING_O <= 1'b0;
    end else begin
      RETAINING_O <= (state_nxt == asc_pkg::ST_RETAIN);
    end
  end
endmodule : asc_ctrl
`default_nettype wire

// *** asc_ctrl_props.sv ***
// pin-level assertions for the memory host controller
`default_nettype none
module asc_ctrl_props (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic [asc_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input wire logic REQ_DATA_I,
  input wire logic MEM_DOUT_I,
  input wire logic REQ_READY_O,
  input wire logic RD_VALID_O,
  input wire logic RD_DATA_O,
  input wire logic RETAINING_O,
  input wire logic [asc_pkg::ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_CS_N_O,
  input wire logic MEM_WE_N_O,
  input wire logic MEM_DIN_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  wire tw = REQ_VALID_I && REQ_READY_O && REQ_WRITE_I;
  wire tr = REQ_VALID_I && REQ_READY_O && !REQ_WRITE_I;
  sequence wr_setup_s; !MEM_CS_N_O && MEM_WE_N_O; endsequence
  sequence wr_pulse_s; !MEM_CS_N_O && !MEM_WE_N_O; endsequence
  sequence wr_end_s; MEM_CS_N_O && MEM_WE_N_O; endsequence
  chk_wr_order: assert property (tw |=> wr_setup_s ##1 wr_pulse_s ##1 wr_end_s)
    else $error("write strobe order wrong");
  chk_wr_data: assert property (tw |=> MEM_DIN_O == $past(REQ_DATA_I)
    ##1 $stable(MEM_DIN_O))
    else $error("write data wrong");
  chk_wr_busy: assert property (tw |=> !REQ_READY_O [*3])
    else $error("write cycle too short");
  chk_rd_valid: assert property (tr |-> ##2 RD_VALID_O ##1 !RD_VALID_O)
    else $error("read pulse wrong");
  chk_rd_strobe: assert property (tr |=> !MEM_CS_N_O && MEM_WE_N_O
    && MEM_ADDR_O == $past(REQ_ADDR_I))
    else $error("read pins wrong");
  chk_rd_data: assert property (RD_VALID_O |-> !$past(MEM_CS_N_O) && $past(MEM_WE_N_O)
    && RD_DATA_O == $past(MEM_DOUT_I))
    else $error("read bit not taken from selected memory");
  chk_addr_hold: assert property (!MEM_CS_N_O && !$past(MEM_CS_N_O)
    |-> $stable(MEM_ADDR_O))
    else $error("address moved while selected");
  chk_we_sel: assert property (!MEM_WE_N_O |-> !MEM_CS_N_O)
    else $error("strobe without select");
  chk_retain_sel: assert property (RETAINING_O |-> MEM_CS_N_O && !REQ_READY_O)
    else $error("selected in retention");
endmodule // asc_ctrl_props
bind asc_ctrl asc_ctrl_props u_asc_ctrl_props (.REF_CLK_I, .RST_I, .REQ_VALID_I, .REQ_WRITE_I,
  .REQ_ADDR_I, .REQ_DATA_I, .MEM_DOUT_I, .REQ_READY_O, .RD_VALID_O, .RD_DATA_O, .RETAINING_O,
  .MEM_ADDR_O, .MEM_CS_N_O, .MEM_WE_N_O, .MEM_DIN_O);
`default_nettype wire

// *** asc_ctrl_tb_top.sv ***
// self-checking bench for the memory host controller
`default_nettype none
module asc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, v = 0, w = 0, d = 0, ret = 0, sok = 1, dout;
  logic rdy, rv, rd, rtn, csn, wen, din;
  logic [13:0] a = 14'h0000, ma;
  int errors = 0, tests_run = 0;
  asc_ctrl u_asc_ctrl (.REF_CLK_I(clk), .RST_I(rst), .REQ_VALID_I(v), .REQ_WRITE_I(w),
    .REQ_ADDR_I(a), .REQ_DATA_I(d), .RETAIN_REQ_I(ret), .SUPPLY_OK_I(sok), .MEM_DOUT_I(dout),
    .REQ_READY_O(rdy), .RD_VALID_O(rv), .RD_DATA_O(rd), .RETAINING_O(rtn), .MEM_ADDR_O(ma),
    .MEM_CS_N_O(csn), .MEM_WE_N_O(wen), .MEM_DIN_O(din));
  asc_mem_model u_asc_mem_model (.addr_i(ma), .cs_n_i(csn), .we_n_i(wen), .din_i(din),
    .dout_o(dout));
  initial forever #25 clk = ~clk;
  task automatic ck(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // resume 2 ns after the edge so design updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic req(input logic wr, input logic [13:0] ad, input logic dt);
    int n;
    n = 0;
    v = 1;
    w = wr;
    a = ad;
    d = dt;
    while (rdy !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    ck(n < 20, "not taken");
    cyc(1);
    v = 0;
  endtask
  task automatic wr_t(input logic [13:0] ad, input logic dt);
    req(1'h1, ad, dt);
    ck(csn === 1'b0 && wen === 1'b1 && din === dt && ma === ad, "wr setup");
    cyc(1);
    ck(csn === 1'b0 && wen === 1'b0, "wr pulse");
    cyc(1);
    ck(csn === 1'b1 && wen === 1'b1, "wr end");
  endtask
  task automatic rd_t(input logic [13:0] ad, input logic ex);
    req(1'h0, ad, 1'h0);
    ck(csn === 1'b0 && wen === 1'b1 && ma === ad, "rd pins");
    cyc(1);
    ck(rv === 1'b1 && rd === ex, "rd data");
  endtask
  task automatic retain_t();
    ret = 1;
    sok = 0;
    cyc(3);
    ck(rtn === 1'b1 && csn === 1'b1 && rdy === 1'b0, "no retention");
    ret = 0;
    cyc(3);
    ck(rtn === 1'b1, "left early");
    sok = 1;
    cyc(1);
    ck(rtn === 1'b1 && csn === 1'b1, "resumed before a read cycle");
    cyc(2);
    ck(rtn === 1'b0 && rdy === 1'b1, "no exit");
  endtask
  task automatic complete_run();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(2);
    rst = 0;
    ck(csn === 1'b1 && wen === 1'b1 && rv === 1'b0 && rdy === 1'b1, "reset");
    wr_t(14'h0000, 1'h1);
    wr_t(14'h3fff, 1'h0);
    wr_t(14'h1555, 1'h1);
    rd_t(14'h3fff, 1'h0);
    rd_t(14'h0000, 1'h1);
    wr_t(14'h0000, 1'h0);
    rd_t(14'h0000, 1'h0);
    retain_t();
    rd_t(14'h1555, 1'h1);
    complete_run();
  end
  // whole run needs about 37 cycles
  initial begin
    #50000;
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end
endmodule // asc_ctrl_tb_top
`default_nettype wire

// *** asc_mem_model.sv ***
// behavioural 16k x 1 static memory
`default_nettype none
module asc_mem_model (
  input wire logic [13:0] addr_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic din_i,
  output logic dout_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mem_r [0:16383];
  wire wr = !cs_n_i && !we_n_i;
  wire rd = !cs_n_i && we_n_i;
  always @(negedge wr) mem_r[addr_i] <= din_i;
  // floating pin shows the inverse, so a stale sample cannot pass
  assign dout_o = rd ? mem_r[addr_i] : ~mem_r[addr_i];
endmodule // asc_mem_model
`default_nettype wire

// *** asc_pkg.sv ***
// constants for the 16k x 1 static memory host controller
`default_nettype none
package asc_pkg;
  localparam int ADDR_W = 14;
  localparam int CLK_PERIOD_NS = 50;
  // speed grade timing, nanoseconds, indexed by grade 0..2
  localparam int T_CYCLE_NS_G0 = 35;
  localparam int T_CYCLE_NS_G1 = 45;
  localparam int T_CYCLE_NS_G2 = 55;
  localparam int T_CS_WR_NS_G0 = 30;
  localparam int T_CS_WR_NS_G1 = 40;
  localparam int T_CS_WR_NS_G2 = 50;
  localparam int T_DATA_WR_NS_G0 = 20;
  localparam int T_DATA_WR_NS_G1 = 25;
  localparam int T_DATA_WR_NS_G2 = 25;
  localparam int TURN_OFF_DELAY_NS = 30;
  localparam int RETAIN_ENTRY_NS = 0;
  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int CYC_W = 4;
  localparam logic [1:0] GRADE_DEFAULT = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD = 3'b001,
    ST_WR_SETUP = 3'b010,
    ST_WR_PULSE = 3'b011,
    ST_RECOVER = 3'b100,
    ST_RETAIN = 3'b101
  } asc_state_e;
endpackage : asc_pkg
`default_nettype wire
